// ===== include/pmcc_pkg.sv
package pmcc_pkg;

   // Special-function register addresses.
   localparam logic [7:0] power_control_register_addr = 8'h87;
   localparam logic [7:0] sleep_mode_control_addr     = 8'hbe;
   localparam logic [7:0] clock_control_addr          = 8'hc6;

   // Sleep mode control fields.
   localparam int crystal_stable_bit       = 6;
   localparam int fast_rc_stable_bit       = 5;
   localparam int reset_cause_lsb          = 3;
   localparam int powerdown_bit            = 2;
   localparam int mode_lsb                 = 0;
   localparam logic powerdown_reset        = 1'b1;
   localparam logic [1:0] mode_reset       = 2'h0;

   // Power control fields.
   localparam int idle_bit                 = 0;

   // Clock control fields.
   localparam int slow_src_bit             = 7;
   localparam int sys_src_bit              = 6;
   localparam int tick_lsb                 = 3;
   localparam int reserved_lsb             = 1;
   localparam int speed_bit                = 0;
   localparam logic slow_src_reset         = 1'b1;
   localparam logic sys_src_reset          = 1'b1;
   localparam logic [2:0] tick_reset       = 3'h1;
   localparam logic [1:0] reserved_reset   = 2'h0;
   localparam logic speed_reset            = 1'b1;

   // Source select encodings.
   localparam logic src_fast_crystal       = 1'b0;
   localparam logic src_fast_rc            = 1'b1;

   typedef enum logic [1:0] {
      cause_power_on = 2'h0,
      cause_external = 2'h1,
      cause_watchdog = 2'h2
   } reset_cause_t;

   typedef struct packed {
      logic fast_crystal_on;
      logic fast_rc_on;
   } osc_power_t;

   typedef struct packed {
      logic fast_crystal_stable;
      logic fast_rc_stable;
   } osc_status_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
      logic [7:0] data;
   } sfr_write_t;

endpackage : pmcc_pkg

// ===== core/tick_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module tick_prescaler
   import pmcc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [2:0] timer_tick_divider,
   output var  logic       tick
);
   logic [6:0] count_reg;
   logic [6:0] count_next;
   logic [6:0] limit;
   logic       wrap;

   // Divide by 2**n: a one-cycle pulse every limit+1 cycles.
   assign limit      = 7'((8'h1 << timer_tick_divider) - 8'h1);
   assign wrap       = (count_reg >= limit);
   assign count_next = wrap ? 7'h0 : 7'(count_reg + 7'h1);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_reg <= 7'h0;
         tick      <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick      <= wrap;
      end
   end
endmodule : tick_prescaler
`default_nettype wire

// ===== core/power_mode_clock_control.sv
// Notes on behaviour
// - Crystal stable flag, bit 6, reset 0.
// - Fast RC stable flag at bit 5.
// - Last reset cause at bits 4:3.
// - Powerdown bit 2 resets 1, idles unused oscillator.
// - Source select change clears powerdown bit.
// - Setting powerdown waits for calibration end.
// - Power mode field bits 1:0, reset 00.
// - Clock bit 7 selects slow source, reset 1.
// - Clock bit 6 selects system source, reset 1.
// - Switch source only when new oscillator stable.
// - Selecting powered-down oscillator powers it up.
// - Tick field 5:3 divides by two-to-the-n.
// - Clock bit 0 reports speed, reset 1.
// - Idle write enters selected mode; reads zero.
// - Wake event clears power mode field.
`timescale 1ns/100ps
`default_nettype none
module power_mode_clock_control
   import pmcc_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire sfr_write_t   sfr_wr,
   input  wire logic [7:0]   sfr_rd_addr,
   output var  logic [7:0]   sfr_rd_data,
   input  wire osc_status_t  osc_status,
   input  wire logic         calibration_busy,
   input  wire logic         reset_cause_valid,
   input  wire logic [1:0]   reset_cause,
   input  wire logic         wake_event,
   output var  osc_power_t   osc_power,
   output var  logic         active_clock_source,
   output var  logic [1:0]   power_mode,
   output var  logic         enter_power_mode,
   output var  logic         timer_tick
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state.
   logic       powerdown_reg;
   logic       pending_pd_reg;
   logic [1:0] mode_reg;
   logic [1:0] cause_reg;
   logic       slow_src_reg;
   logic       sys_src_reg;
   logic [2:0] tick_reg;
   logic [1:0] reserved_reg;
   logic       speed_reg;
   logic       active_reg;
   logic       enter_reg;
   logic       powerdown_next;
   logic       pending_pd_next;
   logic [1:0] mode_next;
   logic [1:0] cause_next;
   logic       slow_src_next;
   logic       sys_src_next;
   logic [2:0] tick_next;
   logic [1:0] reserved_next;
   logic       speed_next;
   logic       active_next;
   logic       enter_next;
   logic [7:0] rd_data_next;

   ////////////////////////////////////////////////////////////////////////////
   // Write decode.
   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
      return (a == b);
   endfunction

   function automatic logic hit(input sfr_write_t w, input logic [7:0] a);
      return w.valid && addr_is(w.addr, a);
   endfunction

   wire        wr_sleep      = hit(sfr_wr, sleep_mode_control_addr);
   wire        wr_clock      = hit(sfr_wr, clock_control_addr);
   wire        wr_power_control_register       = hit(sfr_wr, power_control_register_addr);
   wire        new_src       = sfr_wr.data[sys_src_bit];
   wire        new_slow_src  = sfr_wr.data[slow_src_bit];
   wire [2:0]  new_tick      = sfr_wr.data[tick_lsb +: 3];
   wire [1:0]  new_reserved  = sfr_wr.data[reserved_lsb +: 2];
   wire        new_speed     = sfr_wr.data[speed_bit];
   wire [1:0]  new_mode      = sfr_wr.data[mode_lsb +: 2];
   wire        new_idle      = sfr_wr.data[idle_bit];
   wire        src_toggle    = wr_clock && (new_src != sys_src_reg);
   wire        wr_pd         = sfr_wr.data[powerdown_bit];
   // A set attempt during calibration is parked and applied afterwards.
   wire        defer_set     = wr_sleep && wr_pd && !powerdown_reg && calibration_busy;
   // A later write of zero, or a source toggle, cancels a parked set.
   wire        cancel_pd     = src_toggle || (wr_sleep && !wr_pd);
   wire        target_stable = (sys_src_reg == src_fast_rc) ?
                               osc_status.fast_rc_stable : osc_status.fast_crystal_stable;

   always_comb begin
      powerdown_next = powerdown_reg;
      if (src_toggle) begin
         powerdown_next = 1'b0;
      end else if (wr_sleep && !defer_set) begin
         powerdown_next = wr_pd;
      end else if (pending_pd_reg && !calibration_busy) begin
         powerdown_next = 1'b1;
      end
   end

   assign pending_pd_next = defer_set || (pending_pd_reg && calibration_busy && !cancel_pd);
   // Wake wins over a mode write in the same cycle, so the part cannot fall back asleep.
   assign mode_next       = wake_event ? mode_reset : (wr_sleep ? new_mode : mode_reg);
   assign cause_next      = reset_cause_valid ? reset_cause : cause_reg;
   assign enter_next      = wr_power_control_register && new_idle && !wake_event;
   assign slow_src_next   = wr_clock ? new_slow_src : slow_src_reg;
   assign sys_src_next    = wr_clock ? new_src : sys_src_reg;
   assign tick_next       = wr_clock ? new_tick : tick_reg;
   // Reserved bits are stored as written; keeping them at zero is up to software.
   assign reserved_next   = wr_clock ? new_reserved : reserved_reg;
   assign speed_next      = wr_clock ? new_speed : speed_reg;
   // Hold the old source until the new one is powered and stable.
   assign active_next     = target_stable ? sys_src_reg : active_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Sleep mode control and power control.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         powerdown_reg <= powerdown_reset;
      end else begin
         powerdown_reg <= powerdown_next;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pending_pd_reg <= 1'b0;
      end else begin
         pending_pd_reg <= pending_pd_next;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_reg <= mode_reset;
      end else begin
         mode_reg <= mode_next;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cause_reg <= cause_power_on;
      end else begin
         cause_reg <= cause_next;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         enter_reg <= 1'b0;
      end else begin
         enter_reg <= enter_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock control and source switching.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         slow_src_reg <= slow_src_reset;
      end else begin
         slow_src_reg <= slow_src_next;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sys_src_reg <= sys_src_reset;
      end else begin
         sys_src_reg <= sys_src_next;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_reg <= tick_reset;
      end else begin
         tick_reg <= tick_next;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reserved_reg <= reserved_reset;
      end else begin
         reserved_reg <= reserved_next;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         speed_reg <= speed_reset;
      end else begin
         speed_reg <= speed_next;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         active_reg <= sys_src_reset;
      end else begin
         active_reg <= active_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator power: the running source is always kept on, and the
   // selected one is powered so that a pending switch can complete.
   wire        keep_both        = !powerdown_reg;
   wire        rc_selected      = (sys_src_reg == src_fast_rc);
   wire        rc_running       = (active_reg == src_fast_rc);
   wire        crystal_selected = (sys_src_reg == src_fast_crystal);
   wire        crystal_running  = (active_reg == src_fast_crystal);
   assign osc_power.fast_rc_on      = keep_both || rc_selected || rc_running;
   assign osc_power.fast_crystal_on = keep_both || crystal_selected || crystal_running;
   assign active_clock_source       = active_reg;
   assign power_mode                = mode_reg;
   assign enter_power_mode          = enter_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Read mux.
   // Read data is registered, so it trails the address by one cycle.
   wire [7:0] sleep_view = {1'b0,
                            osc_status.fast_crystal_stable,
                            osc_status.fast_rc_stable,
                            cause_reg, powerdown_reg, mode_reg};
   wire [7:0] clock_view = {slow_src_reg, sys_src_reg, tick_reg, reserved_reg, speed_reg};
   wire       rd_sleep   = addr_is(sfr_rd_addr, sleep_mode_control_addr);
   wire       rd_clock   = addr_is(sfr_rd_addr, clock_control_addr);
   assign rd_data_next = rd_sleep ? sleep_view :
                         rd_clock ? clock_view : 8'h00;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sfr_rd_data <= 8'h00;
      end else begin
         sfr_rd_data <= rd_data_next;
      end
   end

   tick_prescaler u_tick (
      .sys_clk            (sys_clk),
      .sys_rst            (sys_rst),
      .timer_tick_divider (tick_reg),
      .tick               (timer_tick)
   );

endmodule : power_mode_clock_control
`default_nettype wire

// ===== testbench/pmcc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pmcc_checker
   import pmcc_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire sfr_write_t  sfr_wr,
   input wire logic [7:0]  sfr_rd_addr,
   input wire logic [7:0]  sfr_rd_data,
   input wire osc_status_t osc_status,
   input wire logic        wake_event,
   input wire osc_power_t  osc_power,
   input wire logic        active_clock_source,
   input wire logic [1:0]  power_mode,
   input wire logic        enter_power_mode
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   wire sleep_wr = sfr_wr.valid && sfr_wr.addr == sleep_mode_control_addr;
   wire idle_wr  = sfr_wr.valid && sfr_wr.addr == power_control_register_addr && sfr_wr.data[idle_bit];
   ////////////////////////////////////////////////////////////////////////////
   wake_clear_a: assert property (wake_event |=> power_mode == 2'h0)
      else $error("mode kept after wake");
   mode_write_a: assert property (sleep_wr && !wake_event |=> power_mode == $past(sfr_wr.data[1:0]))
      else $error("mode write lost");
   idle_pulse_a: assert property (idle_wr && !wake_event |=> enter_power_mode)
      else $error("no entry pulse");
   idle_cause_a: assert property (enter_power_mode |-> $past(idle_wr))
      else $error("entry pulse without write");
   power_control_register_zero_a: assert property (sfr_rd_addr == power_control_register_addr |=> sfr_rd_data == 8'h00)
      else $error("power control reads nonzero");
   top_bit_a: assert property (sfr_rd_addr == sleep_mode_control_addr |=> !sfr_rd_data[7])
      else $error("sleep top bit set");
   stable_flags_a: assert property (sfr_rd_addr == sleep_mode_control_addr |=>
      sfr_rd_data[6:5] == $past(osc_status))
      else $error("stable flags wrong");
   // Sources only move onto an oscillator that was already reported stable.
   source_switch_a: assert property (!$stable(active_clock_source) |-> (active_clock_source ?
      $past(osc_status.fast_rc_stable) : $past(osc_status.fast_crystal_stable))) else $error("switch unstable");
   source_power_a: assert property (active_clock_source ? osc_power.fast_rc_on :
      osc_power.fast_crystal_on)
      else $error("running source unpowered");
endmodule // pmcc_checker
bind power_mode_clock_control pmcc_checker i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_wr(sfr_wr),
   .sfr_rd_addr(sfr_rd_addr), .sfr_rd_data(sfr_rd_data), .osc_status(osc_status), .wake_event(wake_event),
   .osc_power(osc_power), .active_clock_source(active_clock_source), .power_mode(power_mode),
   .enter_power_mode(enter_power_mode));
`default_nettype wire

// ===== testbench/test_power_mode_clock_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_power_mode_clock_control
   import pmcc_pkg::*;
   ;
   logic        sys_clk, sys_rst, calibration_busy, reset_cause_valid, wake_event;
   logic        active_clock_source, enter_power_mode, timer_tick;
   sfr_write_t  sfr_wr;
   logic [7:0]  sfr_rd_addr, sfr_rd_data;
   osc_status_t osc_status;
   osc_power_t  osc_power;
   logic [1:0]  reset_cause, power_mode;
   int          n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 66236, r, n;
   power_mode_clock_control i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_wr(sfr_wr),
      .sfr_rd_addr(sfr_rd_addr), .sfr_rd_data(sfr_rd_data), .osc_status(osc_status),
      .calibration_busy(calibration_busy), .reset_cause_valid(reset_cause_valid), .reset_cause(reset_cause),
      .wake_event(wake_event), .osc_power(osc_power), .active_clock_source(active_clock_source),
      .power_mode(power_mode), .enter_power_mode(enter_power_mode), .timer_tick(timer_tick));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_mismatch++;
         complete_run;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] sleep_exp(logic [1:0] st, logic [1:0] c, logic pd, logic [1:0] m);
      return {1'b0, st, c, pd, m};
   endfunction
   task automatic step;
      @(posedge sys_clk);
      #2;
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      step;
      sfr_wr = '{1'b1, a, d};
      step;
      sfr_wr.valid = 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      sfr_rd_addr = a;
      step;
      chk("read data", e, sfr_rd_data);
   endtask
   task automatic cause(logic [1:0] c);
      step;
      reset_cause = c;
      reset_cause_valid = 1'b1;
      step;
      reset_cause_valid = 1'b0;
   endtask
   task complete_run;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {sys_rst, sfr_wr, sfr_rd_addr, calibration_busy, reset_cause_valid, reset_cause, wake_event} = '0;
      sys_rst = 1'b1;
      osc_status = '{1'b0, 1'b1};
      repeat (4) @(posedge sys_clk);
      #2 sys_rst = 1'b0;
      rd(sleep_mode_control_addr, 8'h24);
      rd(clock_control_addr, 8'hc9);
      rd(8'h55, 8'h00);
      wr(sleep_mode_control_addr, 8'hff);
      rd(sleep_mode_control_addr, 8'h27);
      wake_event = 1'b1;
      step;
      wake_event = 1'b0;
      chk("power mode", 8'h00, {6'h0, power_mode});
      wr(sleep_mode_control_addr, 8'h06);
      wr(power_control_register_addr, 8'h01);
      chk("idle pulse", 8'h01, {7'h0, enter_power_mode});
      rd(power_control_register_addr, 8'h00);
      chk("idle pulse", 8'h00, {7'h0, enter_power_mode});
      // Two causes back to back: only the later one may remain.
      for (int i = 0; i < 3; i++) begin
         cause(2'h2);
         cause(i[1:0]);
         rd(sleep_mode_control_addr, sleep_exp(2'b01, i[1:0], 1'b1, 2'h2));
      end
      wr(clock_control_addr, 8'h88);
      chk("oscillator power", 8'h03, {6'h0, osc_power});
      chk("active source", 8'h01, {7'h0, active_clock_source});
      rd(sleep_mode_control_addr, sleep_exp(2'b01, 2'h2, 1'b0, 2'h2));
      osc_status.fast_crystal_stable = 1'b1;
      repeat (3) step;
      chk("active source", 8'h00, {7'h0, active_clock_source});
      calibration_busy = 1'b1;
      wr(sleep_mode_control_addr, 8'h06);
      rd(sleep_mode_control_addr, sleep_exp(2'b11, 2'h2, 1'b0, 2'h2));
      osc_status.fast_rc_stable = 1'b0;
      calibration_busy = 1'b0;
      repeat (2) step;
      rd(sleep_mode_control_addr, sleep_exp(2'b10, 2'h2, 1'b1, 2'h2));
      chk("oscillator power", 8'h02, {6'h0, osc_power});
      // A 128-cycle window holds a whole number of periods for every divider.
      for (int d = 0; d < 8; d++) begin
         wr(clock_control_addr, 8'h80 | 8'(d << 3));
         repeat (130) step;
         n = 0;
         repeat (128) begin
            step;
            n += int'(timer_tick);
         end
         chk("tick count", 8'(128 >> d), 8'(n));
      end
      repeat (24) begin
         r = $random(seed);
         step;
         sfr_wr = '{1'b1, sleep_mode_control_addr, r[7:0]};
         wake_event = r[8];
         step;
         sfr_wr.valid = 1'b0;
         wake_event = 1'b0;
         chk("power mode", r[8] ? 8'h00 : {6'h0, r[1:0]}, {6'h0, power_mode});
      end
      complete_run;
   end
endmodule // test_power_mode_clock_control
`default_nettype wire
